/* src/p3c_pkg.sv */
// Constants, field layout and carrier types for the port 3 low-pin
// function select and upper-pin external interrupt edge control.
// Assumes one core clock and the chip reset; no bus beyond the core's
// own register-addressed special function register port.
// Functional notes
// (R1) Registers reachable only by direct register addressing
// (R2) Pin 3.3 field: Schmitt input or slave select
// (R3) Pin 3.2 field: Schmitt input or serial clock
// (R4) Pin 3.0 field code 01: serial data out
// (R5) Code 10 drives LCD segment, 11 output
// (R6) Pin 3.1 field: Schmitt input or serial in
// (R7) Interrupt bits 7-6 set pin 3.7 edge
// (R8) Interrupt bits 5-4 set pin 3.6 edge
// (R9) Edge codes: off, falling, rising, both edges
package p3c_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [7:0] P3C_ADDR_LOW_SEL = 8'hE9; // Low pin function select
	localparam logic [7:0] P3C_ADDR_IRQ_CTL = 8'hEB; // Interrupt edge control
	localparam logic [7:0] P3C_RST_VAL      = 8'h00; // Both registers clear
	localparam logic [7:0] P3C_UNMAP_VAL    = 8'h00; // Unmapped reads

	// ==========================================================
	// Field layout
	// ==========================================================
	localparam int P3C_FLD_W       = 2; // Every field is two bits
	localparam int P3C_NUM_LOW     = 4; // Pins 3.0 to 3.3
	localparam int P3C_NUM_IRQ     = 2; // Pins 3.6 and 3.7
	localparam int P3C_PIN_SS      = 3; // Pin 3.3 slave select
	localparam int P3C_PIN_SCK     = 2; // Pin 3.2 serial clock
	localparam int P3C_PIN_SI      = 1; // Pin 3.1 serial data in
	localparam int P3C_PIN_SO      = 0; // Pin 3.0 serial data out
	localparam int P3C_IRQ_SIX     = 2; // Field index of pin 3.6
	localparam int P3C_IRQ_SEVEN   = 3; // Field index of pin 3.7
	localparam int P3C_SYNC_W      = 6; // Synchronised pad count

	// ==========================================================
	// Field codes
	// ==========================================================
	localparam logic [1:0] P3C_MODE_SCHMITT = 2'h0; // Schmitt input
	localparam logic [1:0] P3C_MODE_SERIAL  = 2'h1; // Serial alt function
	localparam logic [1:0] P3C_MODE_LCD     = 2'h2; // LCD segment drive
	localparam logic [1:0] P3C_MODE_OUTPUT  = 2'h3; // General output
	localparam logic [1:0] P3C_EDGE_OFF     = 2'h0; // Interrupt disabled
	localparam logic [1:0] P3C_EDGE_FALL    = 2'h1; // Falling edge
	localparam logic [1:0] P3C_EDGE_RISE    = 2'h2; // Rising edge
	localparam logic [1:0] P3C_EDGE_BOTH    = 2'h3; // Either edge

	// Drive pair for the four lower pads
	typedef struct packed {
		logic [3:0] out; // Pad output level
		logic [3:0] oe;  // Pad output enable, high drives
	} p3c_pad_s;

	// Two-bit field of a configuration byte
	function automatic logic [1:0] p3c_fld(input logic [7:0] r, input int idx);
		p3c_fld = r[idx*P3C_FLD_W +: P3C_FLD_W];
	endfunction

	// Edge decode for one interrupt pin
	function automatic logic p3c_edge_hit(input logic [1:0] mode,
			input logic old_lvl, input logic new_lvl);
		logic rise;
		logic fall;
		rise = !old_lvl && new_lvl;
		fall = old_lvl && !new_lvl;
		case (mode)
			P3C_EDGE_FALL: p3c_edge_hit = fall;
			P3C_EDGE_RISE: p3c_edge_hit = rise;
			P3C_EDGE_BOTH: p3c_edge_hit = rise || fall;
			default:       p3c_edge_hit = 1'b0;
		endcase
	endfunction

endpackage

/* src/p3c_port3_cfg.sv */
// Port 3 lower-pin function select and upper-pin interrupt edge logic.
// Assumes the core presents register-addressed accesses on its special
// function register port with a flag telling direct from other modes,
// and that pads, serial unit and LCD driver sit on the same clock except
// the pad inputs, which are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module p3c_port3_cfg
	import p3c_pkg::*;
(
	input  wire logic       clk,                // Core clock, 50 MHz
	input  wire logic       rst_n,              // Chip reset, async low
	input  wire logic       reg_sel,            // Register access strobe
	input  wire logic       reg_wr,             // High write, low read
	input  wire logic       reg_direct,         // Direct register addressing
	input  wire logic [7:0] reg_addr,           // Register address
	input  wire logic [7:0] reg_wdata,          // Write data
	output logic      [7:0] reg_rdata,          // Read data, one cycle late
	input  wire logic [3:0] pad_in,             // Pads 3.0 to 3.3 level
	input  wire logic [1:0] irq_pad_in,         // Pads 3.6, 3.7 level
	input  wire logic [3:0] port_data_out,      // Port output latch
	input  wire p3c_pad_s   spi_drv,            // Serial unit pad drive
	input  wire logic [3:0] lcd_seg_drive,      // LCD segment levels
	output p3c_pad_s        pad_drv,            // Lower pad drive
	output logic      [3:0] port_pin_in,        // Synchronised pin levels
	output logic      [2:0] spi_pin_in,         // Serial clk/in/out pin view
	output logic            serial_slave_select_n, // Slave select, low active
	output logic            ext_irq_line_six,   // Pin 3.6 edge pulse
	output logic            ext_irq_line_seven  // Pin 3.7 edge pulse
);

	// ==========================================================
	// Configuration registers
	// ==========================================================
	logic [7:0] low_sel;      // Lower pin function select
	logic [7:0] irq_ctl;      // Interrupt edge control
	logic [7:0] next_low_sel;
	logic [7:0] next_irq_ctl;
	logic [7:0] next_rdata;
	logic       acc_ok;       // Access allowed this cycle

	// Decode of register writes and reads
	always_comb begin
		next_low_sel = low_sel;
		next_irq_ctl = irq_ctl;
		next_rdata   = reg_rdata;
		// (R1) direct addressing only
		acc_ok = reg_sel && reg_direct;
		if (acc_ok && reg_wr) begin
			// Writes in other modes are dropped silently
			if (reg_addr == P3C_ADDR_LOW_SEL) begin
				next_low_sel = reg_wdata;
			end
			if (reg_addr == P3C_ADDR_IRQ_CTL) begin
				next_irq_ctl = reg_wdata;
			end
		end else if (reg_sel && !reg_wr) begin
			// Non-direct reads see zero, not the register
			if (acc_ok && reg_addr == P3C_ADDR_LOW_SEL) begin
				next_rdata = low_sel;
			end else if (acc_ok && reg_addr == P3C_ADDR_IRQ_CTL) begin
				next_rdata = irq_ctl;
			end else begin
				next_rdata = P3C_UNMAP_VAL;
			end
		end
	end

	// Register state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_sel   <= P3C_RST_VAL;
			irq_ctl   <= P3C_RST_VAL;
			reg_rdata <= P3C_UNMAP_VAL;
		end else begin
			low_sel   <= next_low_sel;
			irq_ctl   <= next_irq_ctl;
			reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Pad input synchronisers
	// ==========================================================
	logic [5:0] sync_a;        // First stage, read only by sync_b
	logic [5:0] sync_b;        // Second stage
	logic [5:0] sync_c;        // Third stage
	logic [5:0] pin_lvl;       // Accepted level
	logic [5:0] next_pin_lvl;

	// Level accepted once stages two and three agree; filters one glitch
	always_comb begin
		for (int i = 0; i < P3C_SYNC_W; i++) begin
			next_pin_lvl[i] = (sync_b[i] == sync_c[i]) ? sync_c[i] : pin_lvl[i];
		end
	end

	// Synchroniser chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a  <= '0;
			sync_b  <= '0;
			sync_c  <= '0;
			pin_lvl <= '0;
		end else begin
			sync_a  <= {irq_pad_in, pad_in};
			sync_b  <= sync_a;
			sync_c  <= sync_b;
			pin_lvl <= next_pin_lvl;
		end
	end

	// ==========================================================
	// Lower pin function mux
	// ==========================================================
	p3c_pad_s   next_pad;
	logic [3:0] next_port_in;
	logic [3:0] next_spi_in;    // Bit 3 carries slave select
	logic [3:0] sel_serial;     // Pin handed to serial unit

	// Pad drive and serial input routing per field
	always_comb begin
		next_pad     = '0;
		next_port_in = pin_lvl[3:0];
		sel_serial   = '0;
		for (int p = 0; p < P3C_NUM_LOW; p++) begin
			case (p3c_fld(low_sel, p))
				// (R2) (R3) (R6) Schmitt input
				P3C_MODE_SCHMITT: begin
					next_pad.oe[p] = 1'b0;
				end
				// (R2) (R3) (R4) (R6) serial function
				P3C_MODE_SERIAL: begin
					next_pad.out[p] = spi_drv.out[p];
					next_pad.oe[p]  = spi_drv.oe[p];
					sel_serial[p]   = 1'b1;
				end
				// (R5) LCD segment drive
				P3C_MODE_LCD: begin
					next_pad.out[p] = lcd_seg_drive[p];
					next_pad.oe[p]  = 1'b1;
				end
				// (R5) general output
				P3C_MODE_OUTPUT: begin
					next_pad.out[p] = port_data_out[p];
					next_pad.oe[p]  = 1'b1;
				end
				default: begin
					next_pad.oe[p] = 1'b0;
				end
			endcase
		end
		// Unselected serial inputs rest idle: data low, select high
		next_spi_in = sel_serial & pin_lvl[3:0];
		if (!sel_serial[P3C_PIN_SS]) begin
			next_spi_in[P3C_PIN_SS] = 1'b1;
		end
	end

	// Pad outputs come straight from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_drv               <= '0;
			port_pin_in           <= '0;
			spi_pin_in            <= '0;
			serial_slave_select_n <= 1'b1;
		end else begin
			pad_drv               <= next_pad;
			port_pin_in           <= next_port_in;
			spi_pin_in            <= next_spi_in[2:0];
			serial_slave_select_n <= next_spi_in[P3C_PIN_SS];
		end
	end

	// ==========================================================
	// External interrupt edge detection
	// ==========================================================
	logic [1:0] mode_six;     // Pin 3.6 edge code
	logic [1:0] mode_seven;   // Pin 3.7 edge code
	logic [3:0] settle;       // Ones shift in while the chain loads
	logic [3:0] next_settle;
	logic       next_irq_six;
	logic       next_irq_seven;

	// Edge on the accepted level, qualified by each field
	// Accepted level starts low after reset; a pad already high would look
	// like a rising edge, so edges count only once the chain has filled
	always_comb begin
		next_settle    = {settle[2:0], 1'b1};
		// (R8) pin 3.6 field
		mode_six       = p3c_fld(irq_ctl, P3C_IRQ_SIX);
		// (R7) pin 3.7 field
		mode_seven     = p3c_fld(irq_ctl, P3C_IRQ_SEVEN);
		// (R9) edge code decode
		next_irq_six   = settle[3] && p3c_edge_hit(mode_six, pin_lvl[P3C_NUM_LOW],
			next_pin_lvl[P3C_NUM_LOW]);
		next_irq_seven = settle[3] && p3c_edge_hit(mode_seven, pin_lvl[P3C_NUM_LOW + 1],
			next_pin_lvl[P3C_NUM_LOW + 1]);
	end

	// One-cycle request pulses to the interrupt controller
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle             <= '0;
			ext_irq_line_six   <= 1'b0;
			ext_irq_line_seven <= 1'b0;
		end else begin
			settle             <= next_settle;
			ext_irq_line_six   <= next_irq_six;
			ext_irq_line_seven <= next_irq_seven;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence direct_low_wr;
		reg_sel && reg_wr && reg_direct && reg_addr == P3C_ADDR_LOW_SEL;
	endsequence

	sequence other_wr;
		reg_sel && reg_wr && !reg_direct;
	endsequence

	// (R1) direct write lands
	wr_direct_a: assert property (direct_low_wr |=> low_sel == $past(reg_wdata)) // (R1)
		else $error("direct write did not update low select");
	// (R1) other modes blocked
	wr_blocked_a: assert property (other_wr |=> $stable(low_sel) && $stable(irq_ctl)) // (R1)
		else $error("non-direct write changed a register");
	// (R2) slave select route
	ss_route_a: assert property (p3c_fld(low_sel, P3C_PIN_SS) == P3C_MODE_SERIAL // (R2)
		|=> pad_drv.oe[P3C_PIN_SS] == $past(spi_drv.oe[P3C_PIN_SS])
			&& serial_slave_select_n == $past(pin_lvl[P3C_PIN_SS]))
		else $error("slave select pin not routed");
	// (R3) serial clock route
	sck_route_a: assert property (p3c_fld(low_sel, P3C_PIN_SCK) == P3C_MODE_SERIAL // (R3)
		|=> pad_drv.out[P3C_PIN_SCK] == $past(spi_drv.out[P3C_PIN_SCK]))
		else $error("serial clock pin not routed");
	// (R4) serial out route
	so_route_a: assert property (p3c_fld(low_sel, P3C_PIN_SO) == P3C_MODE_SERIAL // (R4)
		|=> pad_drv.out[P3C_PIN_SO] == $past(spi_drv.out[P3C_PIN_SO]))
		else $error("serial out pin not routed");
	// (R5) LCD and output drive
	lcd_drive_a: assert property (p3c_fld(low_sel, 1) == P3C_MODE_LCD // (R5)
		|=> pad_drv.oe[1] && pad_drv.out[1] == $past(lcd_seg_drive[1]))
		else $error("LCD segment not driven");
	gpo_drive_a: assert property (p3c_fld(low_sel, 0) == P3C_MODE_OUTPUT // (R5)
		|=> pad_drv.oe[0] && pad_drv.out[0] == $past(port_data_out[0]))
		else $error("output mode not driven");
	// (R6) serial in and Schmitt
	si_route_a: assert property (p3c_fld(low_sel, P3C_PIN_SI) == P3C_MODE_SERIAL // (R6)
		|=> spi_pin_in[P3C_PIN_SI] == $past(pin_lvl[P3C_PIN_SI]))
		else $error("serial in pin not routed");
	schmitt_hiz_a: assert property (p3c_fld(low_sel, P3C_PIN_SI) == P3C_MODE_SCHMITT // (R6)
		|=> !pad_drv.oe[P3C_PIN_SI])
		else $error("Schmitt input pin driven");
	// (R7) falling edge pin 3.7
	fall_seven_a: assert property ((mode_seven == P3C_EDGE_FALL) ##1 $fell(pin_lvl[5]) // (R7)
		|-> ext_irq_line_seven)
		else $error("falling edge on pin 3.7 missed");
	// (R8) rising edge pin 3.6
	rise_six_a: assert property ((mode_six == P3C_EDGE_RISE && settle[3]) // (R8)
		##1 $rose(pin_lvl[P3C_NUM_LOW]) |-> ext_irq_line_six)
		else $error("rising edge on pin 3.6 missed");
	// (R9) no edge while loading
	settle_quiet_a: assert property (!settle[3] |=> !ext_irq_line_six && !ext_irq_line_seven) // (R9)
		else $error("interrupt fired before synchroniser filled");
	// (R9) disabled and wrong edge
	irq_off_a: assert property ((mode_six == P3C_EDGE_OFF) |=> !ext_irq_line_six) // (R9)
		else $error("disabled interrupt fired");
	wrong_edge_a: assert property ((mode_seven == P3C_EDGE_RISE) ##1 $fell(pin_lvl[5]) // (R9)
		|-> !ext_irq_line_seven)
		else $error("rising mode fired on falling edge");

endmodule

`default_nettype wire

/* verif/p3c_far_side.sv */
// Far-side model: pads, serial unit, LCD driver and output latch.
// Assumes the bench commands pad levels; drive patterns are fixed.
`timescale 1ns/1ps
`default_nettype none

module p3c_far_side
	import p3c_pkg::*;
(
	input  wire logic [3:0] pin_lvl,    // Commanded lower pad levels
	input  wire logic [1:0] irq_lvl,    // Commanded upper pad levels
	output logic      [3:0] pad_in,     // Lower pad levels
	output logic      [1:0] irq_pad_in, // Upper pad levels
	output p3c_pad_s        spi_drv,    // Serial unit drive
	output logic      [3:0] lcd_seg,    // LCD segment levels
	output logic      [3:0] latch       // Port output latch
);
	// ==========================================================
	// Drive patterns
	// ==========================================================
	// serial drive
	// Distinct from LCD and latch so a wrong route shows
	assign spi_drv = '{out: 4'h5, oe: 4'h9};
	assign lcd_seg = 4'h6;
	assign latch   = 4'hC;
	// Pads held by the bench, never released here
	assign pad_in     = pin_lvl;
	assign irq_pad_in = irq_lvl;
endmodule

`default_nettype wire

/* verif/p3c_port3_cfg_bench.sv */
// Self-checking bench for the port 3 function select and edge control.
// Assumes the far-side model drives fixed serial, LCD and latch levels.
`timescale 1ns/1ps
`default_nettype none

module p3c_port3_cfg_bench
	import p3c_pkg::*;
;
	// ==========================================================
	// Signals
	// ==========================================================
	typedef struct packed {
		logic [7:0] wv;  // Select register value
		logic [3:0] oe;  // Expected enables
		logic [3:0] out; // Expected levels
		logic [3:0] msk; // Pads with a defined level
		logic [2:0] spi; // Expected serial pin view
		logic       ssn; // Expected slave select
	} p3c_row_s;
	p3c_row_s   rows [5] = '{'{8'h00, 4'h0, 4'h0, 4'h0, 3'h0, 1'h1},
		'{8'h55, 4'h9, 4'h5, 4'hF, 3'h5, 1'h0}, '{8'hAA, 4'hF, 4'h6, 4'hF, 3'h0, 1'h1},
		'{8'hFF, 4'hF, 4'hC, 4'hF, 3'h0, 1'h1}, '{8'hD8, 4'hA, 4'hE, 4'hE, 3'h4, 1'h1}};
	logic [7:0] ebv [5] = '{8'h00, 8'h50, 8'hA0, 8'hF0, 8'h90}; // Edge modes
	logic       clk;        // Core clock
	logic       rst_n;      // Chip reset
	logic       reg_sel;    // Access strobe
	logic       reg_wr;     // Write flag
	logic       reg_direct; // Direct addressing
	logic [7:0] reg_addr;   // Address
	logic [7:0] reg_wdata;  // Write data
	logic [7:0] reg_rdata;  // Read data
	logic [3:0] pin_lvl;    // Lower pad levels
	logic [1:0] irq_lvl;    // Upper pad levels
	logic [3:0] pad_in;     // Model pad view
	logic [1:0] irq_pad_in; // Model upper pads
	p3c_pad_s   spi_drv;    // Serial drive
	logic [3:0] lcd_seg;    // Segment levels
	logic [3:0] latch;      // Output latch
	p3c_pad_s   pad_drv;    // Pad drive
	logic [3:0] port_pin_in; // Pin view
	logic [2:0] spi_pin_in; // Serial pin view
	logic       ssn;        // Slave select
	logic       irq6;       // Pin 3.6 pulse
	logic       irq7;       // Pin 3.7 pulse
	logic [7:0] cnt6 = 8'h00; // Pulses seen on 3.6
	logic [7:0] cnt7 = 8'h00; // Pulses seen on 3.7
	logic [7:0] s6;         // Snapshot of cnt6
	logic [7:0] s7;         // Snapshot of cnt7
	int         fails = 0;  // Mismatches
	int         n_tests = 0; // Comparisons

	p3c_far_side far (.pin_lvl(pin_lvl), .irq_lvl(irq_lvl), .pad_in(pad_in),
		.irq_pad_in(irq_pad_in), .spi_drv(spi_drv), .lcd_seg(lcd_seg), .latch(latch));
	p3c_port3_cfg uut (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_direct(reg_direct), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pad_in(pad_in), .irq_pad_in(irq_pad_in),
		.port_data_out(latch), .spi_drv(spi_drv), .lcd_seg_drive(lcd_seg),
		.pad_drv(pad_drv), .port_pin_in(port_pin_in), .spi_pin_in(spi_pin_in),
		.serial_slave_select_n(ssn), .ext_irq_line_six(irq6), .ext_irq_line_seven(irq7));

	// ==========================================================
	// Tasks
	// ==========================================================
	// One access, strobe held for exactly one taking edge
	task automatic acc(input logic w, input logic d, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_sel <= 1'h1;
		reg_wr <= w;
		reg_direct <= d;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_sel <= 1'h0;
		#1;
	endtask
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// Verdict, the only exit
	task automatic close_out();
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock, pulse counters, watchdog
	// ==========================================================
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cnt6 <= cnt6 + {7'h0, irq6};
		cnt7 <= cnt7 + {7'h0, irq7};
	end
	// Whole run is a few hundred cycles
	initial begin
		#(20 * 20000);
		fails++;
		close_out();
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		rst_n = 1'h0;
		reg_sel = 1'h0;
		reg_wr = 1'h0;
		reg_direct = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		pin_lvl = 4'h5;
		irq_lvl = 2'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		acc(1'h0, 1'h1, P3C_ADDR_LOW_SEL, 8'h00);
		chk("sel_reset", P3C_RST_VAL, reg_rdata);
		acc(1'h0, 1'h1, P3C_ADDR_IRQ_CTL, 8'h00);
		chk("irq_reset", P3C_RST_VAL, reg_rdata);
		// Pad mux per code, mixed codes last
		foreach (rows[i]) begin
			acc(1'h1, 1'h1, P3C_ADDR_LOW_SEL, rows[i].wv);
			repeat (2) @(posedge clk);
			#1;
			chk("pad_oe", {4'h0, rows[i].oe}, {4'h0, pad_drv.oe});
			chk("pad_out", {4'h0, rows[i].out}, {4'h0, pad_drv.out & rows[i].msk});
			chk("spi_view", {5'h0, rows[i].spi}, {5'h0, spi_pin_in});
			chk("ss_n", {7'h0, rows[i].ssn}, {7'h0, ssn});
		end
		chk("pin_view", 8'h05, {4'h0, port_pin_in});
		// Non-direct and unmapped accesses leave no trace
		acc(1'h1, 1'h0, P3C_ADDR_LOW_SEL, 8'hFF);
		acc(1'h0, 1'h1, P3C_ADDR_LOW_SEL, 8'h00);
		chk("sel_kept", 8'hD8, reg_rdata);
		acc(1'h0, 1'h0, P3C_ADDR_LOW_SEL, 8'h00);
		chk("indirect_rd", P3C_UNMAP_VAL, reg_rdata);
		acc(1'h1, 1'h1, 8'hEA, 8'hFF);
		acc(1'h0, 1'h1, 8'hEA, 8'h00);
		chk("unmapped", P3C_UNMAP_VAL, reg_rdata);
		// Edge modes on both lines, rise then fall
		foreach (ebv[i]) begin
			acc(1'h1, 1'h1, P3C_ADDR_IRQ_CTL, ebv[i]);
			acc(1'h0, 1'h1, P3C_ADDR_IRQ_CTL, 8'h00);
			chk("irq_ctl", ebv[i], reg_rdata);
			for (int e = 1; e >= 0; e--) begin
				s6 = cnt6;
				s7 = cnt7;
				@(posedge clk);
				irq_lvl <= {2{e[0]}};
				repeat (10) @(posedge clk);
				#1;
				chk("line_seven", {7'h0, ebv[i][6+e]}, cnt7 - s7);
				chk("line_six", {7'h0, ebv[i][4+e]}, cnt6 - s6);
			end
		end
		// Reset in mid-run clears drive and registers; upper pads rise
		// meanwhile and must not count as an edge once reset lifts
		@(posedge clk);
		rst_n <= 1'h0;
		irq_lvl <= 2'h3;
		repeat (2) @(posedge clk);
		#1;
		chk("rst_oe", 8'h00, {4'h0, pad_drv.oe});
		s6 = cnt6;
		s7 = cnt7;
		@(posedge clk);
		rst_n <= 1'h1;
		// Both-edge mode lands before the synchroniser has filled
		acc(1'h1, 1'h1, P3C_ADDR_IRQ_CTL, 8'hF0);
		acc(1'h0, 1'h1, P3C_ADDR_LOW_SEL, 8'h00);
		chk("sel_rst2", P3C_RST_VAL, reg_rdata);
		repeat (6) @(posedge clk);
		#1;
		chk("no_edge_seven", 8'h00, cnt7 - s7);
		chk("no_edge_six", 8'h00, cnt6 - s6);
		close_out();
	end
endmodule

`default_nettype wire
